// >>> design/flash_pkg.sv
// Constants, types and command-table functions for the flash host controller
package flash_pkg;

  // Clock and pin timing
  localparam int CLK_NS       = 20;
  localparam int WE_PULSE_NS  = 100;  // Far above the device's glitch filter
  localparam int ACC_NS       = 90;   // Slowest speed grade access time
  localparam int SYNC_CYC     = 2;
  localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC      = (ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;

  // Completion budgets (longest times, rounded down)
  localparam int unsigned ERASE_MS  = 10000;
  localparam int unsigned BP_US     = 50;
  localparam int unsigned ERASE_CYC = ERASE_MS * (1000000 / CLK_NS);
  localparam int unsigned BP_CYC    = BP_US * 1000 / CLK_NS;

  // Command addresses and codes
  localparam logic [17:0] CMD_ADDR_A      = 18'h05555;
  localparam logic [17:0] CMD_ADDR_B      = 18'h02AAA;
  localparam logic [17:0] BOOT_FIRST      = 18'h00000;
  localparam logic [17:0] BOOT_LAST       = 18'h01FFF;
  localparam logic [17:0] LOCK_STATUS_ADR = 18'h00002;
  localparam logic [7:0]  CODE_AA         = 8'hAA;
  localparam logic [7:0]  CODE_55         = 8'h55;
  localparam logic [7:0]  CODE_SETUP      = 8'h80;
  localparam logic [7:0]  CODE_ERASE      = 8'h10;
  localparam logic [7:0]  CODE_PROGRAM    = 8'hA0;
  localparam logic [7:0]  CODE_LOCKOUT    = 8'h40;
  localparam logic [7:0]  CODE_ID_ENTRY   = 8'h90;
  localparam logic [7:0]  CODE_ID_EXIT    = 8'hF0;

  typedef enum logic [2:0] {
    op_read,
    op_program,
    op_erase,
    op_lockout,
    op_id_entry,
    op_id_exit,
    op_id_exit_short
  } op_e;

  typedef struct packed {
    op_e         op;
    logic [17:0] addr;
    logic [7:0]  data;
  } request_s;

  typedef struct packed {
    logic [17:0] addr;
    logic [7:0]  data;
  } step_s;

  typedef struct packed {
    logic [17:0] address_lines;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [7:0]  data_lines;
    logic        data_oe_n;
  } pins_s;

  localparam pins_s PINS_IDLE = '{18'h00000, 1'b1, 1'b1, 1'b1, 8'h00, 1'b1};

  // Number of write cycles a command needs
  function automatic logic [2:0] seq_len(input op_e op);
    case (op)
      op_erase, op_lockout:    seq_len = 3'h6;
      op_program:              seq_len = 3'h4;
      op_id_entry, op_id_exit: seq_len = 3'h3;
      op_id_exit_short:        seq_len = 3'h1;
      default:                 seq_len = 3'h0;
    endcase
  endfunction

  // Address and data of one write cycle of a command
  function automatic step_s seq_step(input op_e         op,
                                     input logic [2:0]  idx,
                                     input logic [17:0] addr,
                                     input logic [7:0]  data);
    step_s s;
    s.addr = CMD_ADDR_A;
    s.data = CODE_AA;
    if (idx == 3'h1 || idx == 3'h4) begin
      s.addr = CMD_ADDR_B;
      s.data = CODE_55;
    end
    if (idx == 3'h2) begin
      case (op)
        op_erase, op_lockout: s.data = CODE_SETUP;
        op_program:           s.data = CODE_PROGRAM;
        op_id_entry:          s.data = CODE_ID_ENTRY;
        op_id_exit:           s.data = CODE_ID_EXIT;
        default:              s.data = CODE_AA;
      endcase
    end
    if (idx == 3'h3 && op == op_program) begin
      s.addr = addr;
      s.data = data;
    end
    if (idx == 3'h5) begin
      s.data = (op == op_lockout) ? CODE_LOCKOUT : CODE_ERASE;
    end
    if (op == op_id_exit_short) begin
      s.addr = addr;
      s.data = CODE_ID_EXIT;
    end
    return s;
  endfunction

endpackage

// >>> design/flash_bus_cycle.sv
// One asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none

module flash_bus_cycle (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic             write,
  input  wire flash_pkg::step_s step,
  input  wire logic [7:0]       data_in,
  output var  flash_pkg::pins_s pins,
  output var  logic             done,
  output var  logic [7:0]       rdata
);

  typedef enum {ph_idle, ph_setup, ph_active, ph_hold} phase_e;

  phase_e           phase;
  phase_e           next_phase;
  flash_pkg::pins_s next_pins;
  logic             next_done;
  logic [7:0]       next_rdata;
  logic [7:0]       cnt;
  logic [7:0]       next_cnt;
  logic             is_write;
  logic             next_is_write;
  logic [7:0]       sync1;
  logic [7:0]       sync2;

  // Pin data is asynchronous; only sync2 is read by logic
  always_ff @(posedge clock) begin
    sync1 <= data_in;
    sync2 <= sync1;
  end

  // Cycle sequencing; write strobe never overlaps output drive
  always_comb begin
    next_phase    = phase;
    next_pins     = pins;
    next_done     = 1'b0;
    next_rdata    = rdata;
    next_cnt      = cnt;
    next_is_write = is_write;
    case (phase)
      ph_idle: begin
        if (start) begin
          next_pins.address_lines = step.addr;
          next_pins.ce_n          = 1'b0;
          next_is_write           = write;
          if (write) begin
            next_pins.data_lines = step.data;
            next_pins.data_oe_n  = 1'b0;
          end else begin
            next_pins.oe_n = 1'b0;
          end
          next_phase = ph_setup;
        end
      end
      ph_setup: begin
        // Address latches on the later falling strobe, here we_n
        if (is_write) begin
          next_pins.we_n = 1'b0;
          next_cnt       = 8'(flash_pkg::WE_PULSE_CYC - 1);
        end else begin
          next_cnt = 8'(flash_pkg::ACC_CYC - 1);
        end
        next_phase = ph_active;
      end
      ph_active: begin
        if (cnt == 8'h00) begin
          if (is_write) begin
            next_pins.we_n = 1'b1; // Data still held at this edge
          end else begin
            next_rdata     = sync2;
            next_pins.oe_n = 1'b1;
          end
          next_pins.ce_n = 1'b1;
          next_phase     = ph_hold;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      ph_hold: begin
        next_pins.data_oe_n = 1'b1;
        next_done           = 1'b1;
        next_phase          = ph_idle;
      end
      default: next_phase = ph_idle;
    endcase
  end

  // State registers
  always_ff @(posedge clock) begin
    if (rst) begin
      phase    <= ph_idle;
      pins     <= flash_pkg::PINS_IDLE;
      done     <= 1'b0;
      rdata    <= 8'h00;
      cnt      <= 8'h00;
      is_write <= 1'b0;
    end else begin
      phase    <= next_phase;
      pins     <= next_pins;
      done     <= next_done;
      rdata    <= next_rdata;
      cnt      <= next_cnt;
      is_write <= next_is_write;
    end
  end

  // Write strobe low for the full pulse width
  a_we_pulse_width: assert property (@(posedge clock) disable iff (rst)
    $fell(pins.we_n) |-> !pins.we_n [*5])
    else $error("write strobe pulse too short");

  // No write strobe while outputs are enabled
  a_we_oe_apart: assert property (@(posedge clock) disable iff (rst)
    !pins.we_n |-> (pins.oe_n && !pins.ce_n && !pins.data_oe_n))
    else $error("write strobe while output drive low");

endmodule
`default_nettype wire

// >>> design/flash_host.sv
// Host controller issuing command sequences to a parallel flash
`timescale 1ns/1ps
`default_nettype none

module flash_host #(
  parameter int unsigned ERASE_CYCLES   = flash_pkg::ERASE_CYC,
  parameter int unsigned PROGRAM_CYCLES = flash_pkg::BP_CYC
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                req_valid,
  input  wire flash_pkg::request_s req,
  output var  logic                req_ready,
  output var  logic                resp_valid,
  output var  logic [7:0]          resp_data,
  output var  logic                resp_timeout,
  input  wire logic [7:0]          data_in,
  output wire flash_pkg::pins_s    pins
);

  typedef enum {st_idle, st_cmd_wait, st_rd_wait} state_e;

  state_e              state;
  state_e              next_state;
  flash_pkg::request_s cur;
  flash_pkg::request_s next_cur;
  logic [2:0]          idx;
  logic [2:0]          next_idx;
  logic [7:0]          prev;
  logic [7:0]          next_prev;
  logic                have_prev;
  logic                next_have_prev;
  logic [31:0]         timer;
  logic [31:0]         next_timer;
  logic                next_req_ready;
  logic                next_resp_valid;
  logic [7:0]          next_resp_data;
  logic                next_resp_timeout;
  logic                bus_start;
  logic                next_bus_start;
  logic                bus_write;
  logic                next_bus_write;
  flash_pkg::step_s    bus_step;
  flash_pkg::step_s    next_bus_step;
  logic                bus_done;
  logic [7:0]          bus_rdata;
  logic [31:0]         limit;
  logic                polls;
  logic                stable;
  logic [17:0]         poll_addr;

  flash_bus_cycle flash_bus_cycle_i (
    .clock   (clock),
    .rst     (rst),
    .start   (bus_start),
    .write   (bus_write),
    .step    (bus_step),
    .data_in (data_in),
    .pins    (pins),
    .done    (bus_done),
    .rdata   (bus_rdata)
  );

  // Polling parameters of the operation in flight
  always_comb begin
    polls = (cur.op == flash_pkg::op_program) ||
            (cur.op == flash_pkg::op_erase) ||
            (cur.op == flash_pkg::op_lockout);
    limit = (cur.op == flash_pkg::op_erase) ? ERASE_CYCLES : PROGRAM_CYCLES;
    poll_addr = (cur.op == flash_pkg::op_program) ? cur.addr
                                                  : flash_pkg::BOOT_FIRST;
    // Done when bit 6 stops toggling and, for programs, bit 7 matches the programmed data
    stable = have_prev && (bus_rdata[6] == prev[6]) &&
             ((cur.op != flash_pkg::op_program) ||
              (bus_rdata[7] == cur.data[7]));
  end

  // Command sequencer and completion polling
  always_comb begin
    next_state        = state;
    next_cur          = cur;
    next_idx          = idx;
    next_prev         = prev;
    next_have_prev    = have_prev;
    next_timer        = timer;
    next_req_ready    = req_ready;
    next_resp_valid   = 1'b0;
    next_resp_data    = resp_data;
    next_resp_timeout = resp_timeout;
    next_bus_start    = 1'b0;
    next_bus_write    = bus_write;
    next_bus_step     = bus_step;
    case (state)
      st_idle: begin
        if (req_valid && req_ready) begin
          next_cur       = req;
          next_idx       = 3'h0;
          next_have_prev = 1'b0;
          next_timer     = 32'h00000000;
          next_req_ready = 1'b0;
          next_bus_start = 1'b1;
          if (flash_pkg::seq_len(req.op) == 3'h0) begin
            next_bus_write = 1'b0;
            next_bus_step  = '{req.addr, 8'h00};
            next_state     = st_rd_wait;
          end else begin
            // First write of every sequence
            next_bus_write = 1'b1;
            next_bus_step  = flash_pkg::seq_step(req.op, 3'h0,
                                                 req.addr, req.data);
            next_state     = st_cmd_wait;
          end
        end
      end
      st_cmd_wait: begin
        if (bus_done) begin
          if (idx + 3'h1 == flash_pkg::seq_len(cur.op)) begin
            if (polls) begin
              // Poll reads only, no new write, until completion is seen or the budget is spent
              next_bus_start = 1'b1;
              next_bus_write = 1'b0;
              next_bus_step  = '{poll_addr, 8'h00};
              next_state     = st_rd_wait;
            end else begin
              next_resp_valid   = 1'b1;
              next_resp_data    = 8'h00;
              next_resp_timeout = 1'b0;
              next_req_ready    = 1'b1;
              next_state        = st_idle;
            end
          end else begin
            // Remaining writes in table order
            next_idx       = idx + 3'h1;
            next_bus_start = 1'b1;
            next_bus_write = 1'b1;
            next_bus_step  = flash_pkg::seq_step(cur.op, idx + 3'h1,
                                                 cur.addr, cur.data);
          end
        end
      end
      st_rd_wait: begin
        if (polls) begin
          next_timer = timer + 32'h00000001;
        end
        if (bus_done) begin
          if (!polls || stable) begin
            next_resp_valid   = 1'b1;
            next_resp_data    = bus_rdata;
            next_resp_timeout = 1'b0;
            next_req_ready    = 1'b1;
            next_state        = st_idle;
          end else if (timer >= limit) begin
            // Budget spent; report instead of hanging
            next_resp_valid   = 1'b1;
            next_resp_data    = bus_rdata;
            next_resp_timeout = 1'b1;
            next_req_ready    = 1'b1;
            next_state        = st_idle;
          end else begin
            next_prev      = bus_rdata;
            next_have_prev = 1'b1;
            next_bus_start = 1'b1;
          end
        end
      end
      default: next_state = st_idle;
    endcase
  end

  // State registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state        <= st_idle;
      cur          <= '{flash_pkg::op_read, 18'h00000, 8'h00};
      idx          <= 3'h0;
      prev         <= 8'h00;
      have_prev    <= 1'b0;
      timer        <= 32'h00000000;
      req_ready    <= 1'b1;
      resp_valid   <= 1'b0;
      resp_data    <= 8'h00;
      resp_timeout <= 1'b0;
      bus_start    <= 1'b0;
      bus_write    <= 1'b0;
      bus_step     <= '{18'h00000, 8'h00};
    end else begin
      state        <= next_state;
      cur          <= next_cur;
      idx          <= next_idx;
      prev         <= next_prev;
      have_prev    <= next_have_prev;
      timer        <= next_timer;
      req_ready    <= next_req_ready;
      resp_valid   <= next_resp_valid;
      resp_data    <= next_resp_data;
      resp_timeout <= next_resp_timeout;
      bus_start    <= next_bus_start;
      bus_write    <= next_bus_write;
      bus_step     <= next_bus_step;
    end
  end

  // Every sequence except the short identification exit opens with AA at the first command address
  a_seq_opening: assert property (@(posedge clock) disable iff (rst)
    (bus_start && bus_write && idx == 3'h0 && state == st_cmd_wait &&
     cur.op != flash_pkg::op_id_exit_short) |->
    (bus_step.addr == flash_pkg::CMD_ADDR_A &&
     bus_step.data == flash_pkg::CODE_AA))
    else $error("sequence does not open with AA at 5555");

  // Last erase or lockout write carries the right code
  a_seq_final: assert property (@(posedge clock) disable iff (rst)
    (bus_start && bus_write && idx == 3'h5) |->
    (bus_step.addr == flash_pkg::CMD_ADDR_A &&
     bus_step.data == ((cur.op == flash_pkg::op_lockout) ?
       flash_pkg::CODE_LOCKOUT : flash_pkg::CODE_ERASE)))
    else $error("wrong sixth write of erase or lockout");

  // Program target write uses the caller's address and data
  a_prog_target: assert property (@(posedge clock) disable iff (rst)
    (bus_start && bus_write && idx == 3'h3 &&
     cur.op == flash_pkg::op_program) |->
    (bus_step.addr == cur.addr && bus_step.data == cur.data))
    else $error("program target write mismatched");

  // Third write of identification commands
  a_id_code: assert property (@(posedge clock) disable iff (rst)
    (bus_start && bus_write && idx == 3'h2 &&
     (cur.op == flash_pkg::op_id_entry || cur.op == flash_pkg::op_id_exit))
    |-> (bus_step.data == ((cur.op == flash_pkg::op_id_entry) ?
       flash_pkg::CODE_ID_ENTRY : flash_pkg::CODE_ID_EXIT)))
    else $error("wrong identification code");

  // No write is issued while a polled operation is unfinished
  a_wait_done: assert property (@(posedge clock) disable iff (rst)
    (state == st_rd_wait && polls) |-> !(bus_start && bus_write))
    else $error("write issued during completion wait");

  // Clean completion only after two matching polls
  a_poll_match: assert property (@(posedge clock) disable iff (rst)
    (resp_valid && !resp_timeout && polls) |->
    ($past(bus_rdata[6]) == $past(prev[6]) && $past(have_prev)))
    else $error("completion reported while bit 6 toggling");

  // Response returns the controller to ready in the same cycle
  a_resp_ready: assert property (@(posedge clock) disable iff (rst)
    resp_valid |-> (req_ready && state == st_idle && !$past(resp_valid)))
    else $error("response without ready");

endmodule
`default_nettype wire

// >>> bench/flash_model.sv
// Behavioural model of the parallel flash facing the host controller
`timescale 1ns/1ps
`default_nettype none

module flash_model #(
  parameter int         PROG_NS  = 1000,
  parameter int         ERASE_NS = 2000,
  parameter int         SLOW_NS  = 6000,
  parameter int         ACC_NS   = 60,
  parameter logic [7:0] MAKER    = 8'h3C, // Arbitrary identity value
  parameter logic [7:0] PART     = 8'hA5  // Arbitrary identity value
) (
  input  wire flash_pkg::pins_s pins,
  input  wire logic [7:0]       bus,
  input  wire logic             slow,
  output var  logic [7:0]       bus_val
);
  logic [7:0]  mem [0:262143];
  logic [7:0]  last_d;
  logic [7:0]  v;
  logic [17:0] wa;
  logic [2:0]  st;
  logic        id_mode;
  logic        locked;
  logic        erasing;
  logic        tog;
  logic        wr;
  logic        rd;
  realtime     t0;
  realtime     busy_end;
  // Strobe decode; output drive low blocks any write
  assign wr = !pins.ce_n && !pins.we_n && pins.oe_n;
  assign rd = !pins.ce_n && !pins.oe_n && pins.we_n;
  // Non-erased start pattern so an erase is visible
  initial begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'hC5;
    {st, id_mode, locked, erasing, tog, last_d, bus_val} = '0;
    busy_end = 0.0;
  end
  // Chip erase; a locked boot block keeps its bytes
  task automatic erase_all();
    for (int i = 0; i < 262144; i++)
      if (!(locked && i < 32'h2000)) mem[i] = 8'hFF;
  endtask
  // Command decoder; a stray write drops the partial sequence
  task automatic cmd(input logic [17:0] a, input logic [7:0] d);
    logic ha;
    logic hb;
    ha = (a == flash_pkg::CMD_ADDR_A);
    hb = (a == flash_pkg::CMD_ADDR_B);
    if ($realtime < busy_end) return;
    case (st)
      3'h0: begin
        if (ha && d == 8'hAA) st = 3'h1;
        else if (d == 8'hF0) id_mode = 1'b0;
      end
      3'h1: st = (hb && d == 8'h55) ? 3'h2 : 3'h0;
      3'h2: begin
        st = 3'h0;
        if (ha && d == 8'hA0) st = 3'h6;
        if (ha && d == 8'h80) st = 3'h3;
        if (ha && d == 8'h90) id_mode = 1'b1;
        if (ha && d == 8'hF0) id_mode = 1'b0;
      end
      3'h3: st = (ha && d == 8'hAA) ? 3'h4 : 3'h0;
      3'h4: st = (hb && d == 8'h55) ? 3'h5 : 3'h0;
      3'h5: begin
        st = 3'h0;
        if (ha && d == 8'h10) begin
          erase_all();
          erasing = 1'b1;
          busy_end = $realtime + ERASE_NS;
        end
        if (ha && d == 8'h40) locked = 1'b1;
      end
      default: begin
        st = 3'h0;
        erasing = 1'b0;
        last_d = d;
        if (!(locked && a <= flash_pkg::BOOT_LAST)) begin
          mem[a] = mem[a] & d;
          busy_end = $realtime + (slow ? SLOW_NS : PROG_NS);
        end
      end
    endcase
  endtask
  // Address taken when the later strobe falls
  always @(posedge wr) begin
    t0 = $realtime;
    wa = pins.address_lines;
  end
  // Data taken at the first rise; glitches never reach the decoder
  always @(negedge wr) begin
    if ($realtime - t0 >= 15.0 && !$isunknown({wa, bus})) cmd(wa, bus);
  end
  // Busy reads carry status bits instead of data
  always @(posedge rd) begin
    if ($realtime < busy_end) begin
      tog = ~tog;
      v = erasing ? {1'b0, tog, 6'h00} : {~last_d[7], tog, last_d[5:0]};
    end else if (id_mode && pins.address_lines[17:2] == 16'h0000)
      v = pins.address_lines[1] ? {7'h00, locked} :
          pins.address_lines[0] ? PART : MAKER;
    else
      v = mem[pins.address_lines];
    bus_val <= #(ACC_NS) v;
  end
  // Released bus shows the inverse, not a stale match
  always @(negedge rd) bus_val <= #(10) ~bus_val;
endmodule

`default_nettype wire

// >>> bench/parallel_flash_command_engine_tb_top.sv
// Self-checking bench for the flash host controller and flash model
`timescale 1ns/1ps
`default_nettype none

module parallel_flash_command_engine_tb_top;
  localparam logic [7:0] MAKER = 8'h3C; // Arbitrary identity value
  localparam logic [7:0] PART  = 8'hA5; // Arbitrary identity value
  logic                clock;
  logic                rst;
  logic                req_valid;
  flash_pkg::request_s req;
  logic                req_ready;
  logic                resp_valid;
  logic [7:0]          resp_data;
  logic                resp_timeout;
  wire flash_pkg::pins_s pins;
  logic [7:0]          bus_val;
  wire  [7:0]          data_in;
  logic                slow;
  logic [7:0]          got;
  logic                got_to;
  int                  bad_count;
  int                  cmp_count;
  // Host drives the data pins while its enable is low
  assign data_in = (pins.data_oe_n == 1'b0) ? pins.data_lines : bus_val;
  flash_host #(.ERASE_CYCLES(200), .PROGRAM_CYCLES(100)) flash_host_i (
    .clock(clock), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_data(resp_data), .resp_timeout(resp_timeout),
    .data_in(data_in), .pins(pins));
  flash_model #(.MAKER(MAKER), .PART(PART)) flash_model_i (
    .pins(pins), .bus(data_in), .slow(slow), .bus_val(bus_val));
  always #10 clock = ~clock;
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic seen);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, seen);
    end
  endtask
  // One request, then a bounded wait for its response pulse
  task automatic run(input flash_pkg::op_e op, input logic [17:0] a,
                     input logic [7:0] d);
    int n;
    req <= '{op, a, d};
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (resp_valid !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      bad_count++;
      $display("[FAIL] response expected 1 seen none");
      stop_test();
    end
    got = resp_data;
    got_to = resp_timeout;
    chk1("ready with response", 1'b1, req_ready);
    @(posedge clock);
  endtask
  task automatic rd_chk(input string what, input logic [17:0] a,
                        input logic [7:0] exp);
    run(flash_pkg::op_read, a, 8'h00);
    chk8(what, exp, got);
  endtask
  // Stored byte, then chip erase leaves every bit set
  task automatic t_erase();
    rd_chk("array byte", 18'h30010, 8'hD5);
    run(flash_pkg::op_erase, 18'h00000, 8'h00);
    chk1("erase timeout", 1'b0, got_to);
    rd_chk("erased main", 18'h30010, 8'hFF);
    rd_chk("erased boot", 18'h00100, 8'hFF);
  endtask
  // Program polls to true data; a second program only clears bits
  task automatic t_program();
    run(flash_pkg::op_program, 18'h30010, 8'h5A);
    chk1("program timeout", 1'b0, got_to);
    chk8("program poll", 8'h5A, got);
    run(flash_pkg::op_program, 18'h30010, 8'h0F);
    rd_chk("reprogram", 18'h30010, 8'h0A);
  endtask
  // Identification codes and both ways out
  task automatic t_ident();
    run(flash_pkg::op_id_entry, 18'h00000, 8'h00);
    rd_chk("maker", 18'h00000, MAKER);
    rd_chk("part", 18'h00001, PART);
    rd_chk("lock clear", 18'h00002, 8'h00);
    run(flash_pkg::op_id_exit_short, 18'h12345, 8'h00);
    rd_chk("short exit", 18'h00001, 8'hFF);
    run(flash_pkg::op_id_entry, 18'h00000, 8'h00);
    run(flash_pkg::op_id_exit, 18'h00000, 8'h00);
    rd_chk("long exit", 18'h00000, 8'hFF);
  endtask
  // Lockout freezes the last boot byte, not the first main byte
  task automatic t_lockout();
    run(flash_pkg::op_program, 18'h01FFF, 8'h33);
    run(flash_pkg::op_lockout, 18'h00000, 8'h00);
    run(flash_pkg::op_id_entry, 18'h00000, 8'h00);
    rd_chk("lock set", 18'h00002, 8'h01);
    run(flash_pkg::op_id_exit_short, 18'h00000, 8'h00);
    run(flash_pkg::op_program, 18'h01FFF, 8'h00);
    rd_chk("locked byte", 18'h01FFF, 8'h33);
    run(flash_pkg::op_program, 18'h02000, 8'h11);
    rd_chk("main byte", 18'h02000, 8'h11);
    run(flash_pkg::op_erase, 18'h00000, 8'h00);
    rd_chk("boot kept", 18'h01FFF, 8'h33);
    rd_chk("main erased", 18'h02000, 8'hFF);
  endtask
  // A program that outlasts the poll budget is reported
  task automatic t_timeout();
    slow <= 1'b1;
    run(flash_pkg::op_program, 18'h30020, 8'h77);
    chk1("slow timeout", 1'b1, got_to);
    slow <= 1'b0;
    repeat (400) @(posedge clock);
    rd_chk("slow result", 18'h30020, 8'h77);
  endtask
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    slow = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_erase();
    t_program();
    t_ident();
    t_lockout();
    t_timeout();
    stop_test();
  end
endmodule

`default_nettype wire
